/* hdl/ctt_pkg.sv */
package ctt_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] VT_CFG_ADDR = 8'h05;
    localparam logic [7:0] CT_CFG_ADDR = 8'h06;
    localparam logic [7:0] VT_CFG_RST = 8'h6B;
    localparam logic [7:0] CT_CFG_RST = 8'h38;
    localparam logic [7:0] CT_CFG_RD_MASK = 8'h3E;
    // ==========================================================
    // Voltage threshold fields
    localparam int RCH_DIS_BIT = 7;
    localparam int RCH_SEL_HI = 6;
    localparam int RCH_SEL_LO = 5;
    localparam int TRK_SEL_HI = 4;
    localparam int TRK_SEL_LO = 3;
    localparam int WEAK_SEL_HI = 2;
    localparam int WEAK_SEL_LO = 0;
    // ==========================================================
    // Timer fields
    localparam int TEND_EN_BIT = 5;
    localparam int CHG_TMR_EN_BIT = 4;
    localparam int CHG_PER_BIT = 3;
    localparam int WD_EN_BIT = 2;
    localparam int WD_PER_BIT = 1;
    localparam int WD_RESTART_BIT = 0;
    // ==========================================================
    // Threshold tables in mV
    localparam logic [11:0] RCH_BASE_MV = 12'h050;
    localparam logic [11:0] RCH_STEP_MV = 12'h03C;
    localparam logic [11:0] TRK_00_MV = 12'h7D0;
    localparam logic [11:0] TRK_01_MV = 12'h9C4;
    localparam logic [11:0] TRK_10_MV = 12'hA28;
    localparam logic [11:0] TRK_11_MV = 12'hB54;
    localparam logic [11:0] WEAK_BASE_MV = 12'hA8C;
    localparam logic [11:0] WEAK_STEP_MV = 12'h064;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 18;
    localparam int CNT_W = 26;
    localparam int MS_PER_S = 1000;
    localparam int MS_PER_MIN = 60_000;
    localparam int TRK_SHORT_S = 30;
    localparam int TRK_LONG_S = 60;
    localparam int FAST_SHORT_MIN = 300;
    localparam int FAST_LONG_MIN = 600;
    localparam int WD_SHORT_S = 32;
    localparam int WD_LONG_S = 64;
    localparam int SAFETY_MIN = 40;
    localparam int DEGLITCH_MS = 31;
    localparam int TEND_MS_DEF = 1000;
    localparam logic [CNT_W-1:0] TRK_SHORT_T = CNT_W'(TRK_SHORT_S * MS_PER_S / TICK_MS);
    localparam logic [CNT_W-1:0] TRK_LONG_T = CNT_W'(TRK_LONG_S * MS_PER_S / TICK_MS);
    localparam logic [CNT_W-1:0] FAST_SHORT_T = CNT_W'(FAST_SHORT_MIN * MS_PER_MIN / TICK_MS);
    localparam logic [CNT_W-1:0] FAST_LONG_T = CNT_W'(FAST_LONG_MIN * MS_PER_MIN / TICK_MS);
    localparam logic [CNT_W-1:0] WD_SHORT_T = CNT_W'(WD_SHORT_S * MS_PER_S / TICK_MS);
    localparam logic [CNT_W-1:0] WD_LONG_T = CNT_W'(WD_LONG_S * MS_PER_S / TICK_MS);
    localparam logic [CNT_W-1:0] SAFETY_T = CNT_W'(SAFETY_MIN * MS_PER_MIN / TICK_MS);
    localparam logic [CNT_W-1:0] DEGLITCH_T = CNT_W'(DEGLITCH_MS / TICK_MS);
endpackage

/* hdl/ctt_ms_timer.sv */
`timescale 1ns/1ps
module ctt_ms_timer
    import ctt_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic run,
    input wire logic clear,
    input wire logic [CNT_W-1:0] limit,
    output logic expired
);
    // ==========================================================
    // Tick counter, sticky expiry until cleared
    logic [CNT_W-1:0] cnt_r;
    logic expired_r;
    wire last_tick = (cnt_r >= limit - CNT_W'(1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            expired_r <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                cnt_r <= '0;
                expired_r <= 1'b0;
            end else if (run && tick && !expired_r) begin
                cnt_r <= last_tick ? '0 : cnt_r + CNT_W'(1);
                expired_r <= last_tick;
            end
        end
    end

    assign expired = expired_r;
endmodule

/* hdl/ctt_regs_top.sv */
`timescale 1ns/1ps
// Behaviour
// - Recharge allowed while bit 7 is 0, suppressed at 1; resets 0.
// - Recharge margin code 00..11 gives 80, 140, 200, 260 mV; resets 11.
// - Trickle-to-fast level 2.0, 2.5, 2.6, 2.9 V; resets code 01.
// - Weak level 2.7 V plus 0.1 V per code step; resets 011.
// - Complete timer enable off gives 31 ms deglitch only; resets 1.
// - Trickle and fast timers run only while enable is 1; resets 1.
// - Period bit 0 gives 30 s trickle, 300 min fast timeout.
// - Period bit 1, the reset value, gives 60 s and 600 min.
// - Watchdog and safety timer off while enable is 0; resets 0.
// - Watchdog period bit 0 gives 32 s watchdog, 40 min safety.
// - Watchdog period bit 1 gives 64 s watchdog, 40 min safety.
// - Host writing 1 to restart bit restarts watchdog and safety timers.
module ctt_regs_top
    import ctt_pkg::*;
#(
    parameter int MS_TICK_CYCLES = TICK_CYCLES,
    parameter int TEND_MS = TEND_MS_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire logic trickle_active,
    input wire logic fast_active,
    input wire logic end_of_charge_raw,
    input wire logic battery_above_weak_raw,
    output logic recharge_allowed,
    output logic [11:0] recharge_margin_mv,
    output logic [11:0] trickle_to_fast_level_mv,
    output logic [11:0] weak_battery_level_mv,
    output logic trickle_timeout,
    output logic fast_timeout,
    output logic charge_complete,
    output logic watchdog_timeout,
    output logic safety_timeout
);
    // ==========================================================
    // Functions
    function automatic logic [11:0] lin_mv(input logic [11:0] base, input logic [11:0] step,
                                           input logic [2:0] code);
        lin_mv = base + 12'(step * code);
    endfunction

    function automatic logic [11:0] trk_mv(input logic [1:0] code);
        case (code)
            2'h0: trk_mv = TRK_00_MV;
            2'h1: trk_mv = TRK_01_MV;
            2'h2: trk_mv = TRK_10_MV;
            default: trk_mv = TRK_11_MV;
        endcase
    endfunction

    // ==========================================================
    // Register file
    logic [7:0] vt_cfg_r;
    logic [7:0] ct_cfg_r;
    wire vt_wr = reg_wr && (reg_addr == VT_CFG_ADDR);
    wire ct_wr = reg_wr && (reg_addr == CT_CFG_ADDR);
    wire wd_restart = ct_wr && reg_wdata[WD_RESTART_BIT];
    wire [7:0] rd_mux = (reg_addr == VT_CFG_ADDR) ? vt_cfg_r :
                        (reg_addr == CT_CFG_ADDR) ? (ct_cfg_r & CT_CFG_RD_MASK) : 8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vt_cfg_r <= VT_CFG_RST;
            ct_cfg_r <= CT_CFG_RST;
            reg_rdata <= 8'h00;
        end else if (ce) begin
            if (vt_wr) begin
                vt_cfg_r <= reg_wdata;
            end
            if (ct_wr) begin
                ct_cfg_r <= reg_wdata & CT_CFG_RD_MASK;
            end
            reg_rdata <= rd_mux;
        end
    end

    wire rch_dis = vt_cfg_r[RCH_DIS_BIT];
    wire [1:0] rch_sel = vt_cfg_r[RCH_SEL_HI:RCH_SEL_LO];
    wire [1:0] trk_sel = vt_cfg_r[TRK_SEL_HI:TRK_SEL_LO];
    wire [2:0] weak_sel = vt_cfg_r[WEAK_SEL_HI:WEAK_SEL_LO];
    wire tend_en = ct_cfg_r[TEND_EN_BIT];
    wire chg_tmr_en = ct_cfg_r[CHG_TMR_EN_BIT];
    wire chg_per = ct_cfg_r[CHG_PER_BIT];
    wire wd_en = ct_cfg_r[WD_EN_BIT];
    wire wd_per = ct_cfg_r[WD_PER_BIT];

    // ==========================================================
    // Threshold outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            recharge_allowed <= 1'b0;
            recharge_margin_mv <= 12'h000;
            trickle_to_fast_level_mv <= 12'h000;
            weak_battery_level_mv <= 12'h000;
        end else if (ce) begin
            recharge_allowed <= !rch_dis;
            recharge_margin_mv <= lin_mv(RCH_BASE_MV, RCH_STEP_MV, {1'b0, rch_sel});
            trickle_to_fast_level_mv <= trk_mv(trk_sel);
            weak_battery_level_mv <= lin_mv(WEAK_BASE_MV, WEAK_STEP_MV, weak_sel);
        end
    end

    // ==========================================================
    // Comparator input synchronisers
    logic [2:0] eoc_sync_r;
    logic [2:0] weak_sync_r;
    logic eoc_r;
    logic above_weak_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eoc_sync_r <= 3'h0;
            weak_sync_r <= 3'h0;
            eoc_r <= 1'b0;
            above_weak_r <= 1'b0;
        end else if (ce) begin
            eoc_sync_r <= {eoc_sync_r[1:0], end_of_charge_raw};
            weak_sync_r <= {weak_sync_r[1:0], battery_above_weak_raw};
            if (eoc_sync_r[1] == eoc_sync_r[2]) begin
                eoc_r <= eoc_sync_r[2];
            end
            if (weak_sync_r[1] == weak_sync_r[2]) begin
                above_weak_r <= weak_sync_r[2];
            end
        end
    end

    // ==========================================================
    // Millisecond tick
    logic [TICK_W-1:0] tick_cnt_r;
    logic tick_r;
    wire tick_wrap = (tick_cnt_r == TICK_W'(MS_TICK_CYCLES - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (ce) begin
            tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);
            tick_r <= tick_wrap;
        end
    end

    // ==========================================================
    // Timers
    wire trk_run = chg_tmr_en && trickle_active;
    wire fast_run = chg_tmr_en && fast_active;
    wire [CNT_W-1:0] trk_limit = chg_per ? TRK_LONG_T : TRK_SHORT_T;
    wire [CNT_W-1:0] fast_limit = chg_per ? FAST_LONG_T : FAST_SHORT_T;
    wire [CNT_W-1:0] end_limit = tend_en ? CNT_W'(TEND_MS / TICK_MS) : DEGLITCH_T;
    wire wd_run = wd_en && above_weak_r;
    wire [CNT_W-1:0] wd_limit = wd_per ? WD_LONG_T : WD_SHORT_T;
    wire wd_clear = !wd_run || wd_restart;

    ctt_ms_timer u_trk (.clock(clock), .rst(rst), .ce(ce), .tick(tick_r), .run(trk_run),
        .clear(!trk_run), .limit(trk_limit), .expired(trickle_timeout));
    ctt_ms_timer u_fast (.clock(clock), .rst(rst), .ce(ce), .tick(tick_r), .run(fast_run),
        .clear(!fast_run), .limit(fast_limit), .expired(fast_timeout));
    ctt_ms_timer u_end (.clock(clock), .rst(rst), .ce(ce), .tick(tick_r), .run(eoc_r),
        .clear(!eoc_r), .limit(end_limit), .expired(charge_complete));
    ctt_ms_timer u_wd (.clock(clock), .rst(rst), .ce(ce), .tick(tick_r), .run(wd_run),
        .clear(wd_clear), .limit(wd_limit), .expired(watchdog_timeout));
    ctt_ms_timer u_safe (.clock(clock), .rst(rst), .ce(ce), .tick(tick_r), .run(wd_run),
        .clear(wd_clear), .limit(SAFETY_T), .expired(safety_timeout));

    // ==========================================================
    // Assertions
    a_rch_disable: assert property (@(posedge clock) disable iff (rst)
        ce && vt_wr ##1 ce |=> recharge_allowed == !$past(reg_wdata[RCH_DIS_BIT], 2))
        else $error("recharge enable does not follow written bit");
    a_margin_map: assert property (@(posedge clock) disable iff (rst)
        ce && !rst |=> recharge_margin_mv == 12'(80 + 60 * $past(rch_sel)))
        else $error("recharge margin wrong for code");
    a_trk_level: assert property (@(posedge clock) disable iff (rst)
        ce && !rst |=> trickle_to_fast_level_mv == ($past(trk_sel) == 2'h0 ? 12'd2000 :
        $past(trk_sel) == 2'h1 ? 12'd2500 : $past(trk_sel) == 2'h2 ? 12'd2600 : 12'd2900))
        else $error("trickle to fast level wrong");
    a_weak_level: assert property (@(posedge clock) disable iff (rst)
        ce && !rst |=> weak_battery_level_mv == 12'(2700 + 100 * $past(weak_sel)))
        else $error("weak level wrong for code");
    a_end_deglitch: assert property (@(posedge clock) disable iff (rst)
        !tend_en |-> end_limit == CNT_W'(31))
        else $error("deglitch period not 31 ms");
    a_chg_gate: assert property (@(posedge clock) disable iff (rst)
        ce && !chg_tmr_en |=> !trickle_timeout && !fast_timeout)
        else $error("charge timer active while disabled");
    a_chg_period: assert property (@(posedge clock) disable iff (rst)
        trk_limit == (chg_per ? CNT_W'(60000) : CNT_W'(30000))
        && fast_limit == (chg_per ? CNT_W'(36000000) : CNT_W'(18000000)))
        else $error("charge timer period wrong");
    a_chg_long: assert property (@(posedge clock) disable iff (rst)
        chg_per |-> trk_limit == CNT_W'(60000) && fast_limit == CNT_W'(36000000))
        else $error("long charge timer period wrong");
    a_trk_clear: assert property (@(posedge clock) disable iff (rst)
        ce && !trickle_active |=> !trickle_timeout)
        else $error("trickle timeout held outside trickle phase");
    a_wd_gate: assert property (@(posedge clock) disable iff (rst)
        ce && !wd_en |=> !watchdog_timeout && !safety_timeout)
        else $error("watchdog active while disabled");
    a_watchdog_period_sel: assert property (@(posedge clock) disable iff (rst)
        wd_limit == (wd_per ? CNT_W'(64000) : CNT_W'(32000)) && SAFETY_T == CNT_W'(2400000))
        else $error("watchdog period wrong");
    a_wd_long: assert property (@(posedge clock) disable iff (rst)
        wd_per |-> wd_limit == CNT_W'(64000) && SAFETY_T == CNT_W'(2400000))
        else $error("long watchdog period wrong");
    a_wd_weak: assert property (@(posedge clock) disable iff (rst)
        ce && !above_weak_r |=> !watchdog_timeout && !safety_timeout)
        else $error("watchdog active with battery below weak level");
    a_wd_restart: assert property (@(posedge clock) disable iff (rst)
        ce && wd_restart |=> !watchdog_timeout && !safety_timeout)
        else $error("restart did not clear watchdog");
    a_ct_readback: assert property (@(posedge clock) disable iff (rst)
        ce && reg_addr == CT_CFG_ADDR |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[0])
        else $error("unused timer bits read non-zero");
endmodule

/* sim/ctt_host_model.sv */
`timescale 1ns/1ps
module ctt_host_model
    import ctt_pkg::*;
(
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic rd_strobe,
    input wire logic clock
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        rd_strobe = 1'b0;
    end
    // ==========================================================
    // Byte write, one strobe cycle, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // ==========================================================
    // Watchdog service: restart bit written high
    task automatic restart(input logic [7:0] cfg);
        wr(CT_CFG_ADDR, cfg | 8'h01);
    endtask
    // ==========================================================
    // Read: address, then data valid for the watcher one edge later
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        @(posedge clock);
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
    endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench
    import ctt_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic trickle_active = 1'b0;
    logic fast_active = 1'b0;
    logic end_of_charge_raw = 1'b0;
    logic battery_above_weak_raw = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, rd_strobe, recharge_allowed, trickle_timeout, fast_timeout;
    logic charge_complete, watchdog_timeout, safety_timeout;
    logic [11:0] recharge_margin_mv, trickle_to_fast_level_mv, weak_battery_level_mv;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int checks = 0;
    int seed = 45820;
    int n, r;
    int trk_tab[4] = '{2000, 2500, 2600, 2900};
    logic [7:0] d;
    always #2 clock = ~clock;
    ctt_regs_top #(.MS_TICK_CYCLES(1), .TEND_MS(5)) ctt_regs_top_inst (.clock(clock), .rst(rst),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .trickle_active(trickle_active), .fast_active(fast_active),
        .end_of_charge_raw(end_of_charge_raw), .battery_above_weak_raw(battery_above_weak_raw),
        .recharge_allowed(recharge_allowed), .recharge_margin_mv(recharge_margin_mv),
        .trickle_to_fast_level_mv(trickle_to_fast_level_mv),
        .weak_battery_level_mv(weak_battery_level_mv), .trickle_timeout(trickle_timeout),
        .fast_timeout(fast_timeout), .charge_complete(charge_complete),
        .watchdog_timeout(watchdog_timeout), .safety_timeout(safety_timeout));
    ctt_host_model ctt_host_model_inst (.reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .rd_strobe(rd_strobe), .clock(clock));
    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        ctt_host_model_inst.rd(a);
    endtask
    // Bounded wait for a timer output, n counts edges
    task automatic wait_hi(input int sel, input int lim);
        n = 0;
        while (!((sel == 0 && charge_complete === 1'b1) || (sel == 1 && trickle_timeout === 1'b1)
                || (sel == 2 && watchdog_timeout === 1'b1)) && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (n >= lim) begin
            n_errors++;
            $display("ERROR t=%0t timer output never rose", $time);
            report_and_stop();
        end
    endtask
    // ==========================================================
    // Read data watcher
    always @(posedge clock) begin
        if (rd_strobe === 1'b1) check(reg_rdata, exp_q.pop_front());
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(VT_CFG_ADDR, 8'h6B);
        rd(CT_CFG_ADDR, 8'h38);
        rd(8'h07, 8'h00);
        check({recharge_allowed, recharge_margin_mv}, {1'b1, 12'h104});
        check({trickle_to_fast_level_mv, weak_battery_level_mv}, {12'h9C4, 12'hBB8});
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            d = {r[7], i[1:0], i[1:0], i[2:0]};
            ctt_host_model_inst.wr(VT_CFG_ADDR, d);
            rd(VT_CFG_ADDR, d);
            check(recharge_allowed, !r[7]);
            check(recharge_margin_mv, 80 + 60 * i[1:0]);
            check(trickle_to_fast_level_mv, trk_tab[i[1:0]]);
            check(weak_battery_level_mv, 2700 + 100 * i);
        end
        ce <= 1'b0;
        ctt_host_model_inst.wr(VT_CFG_ADDR, ~d);
        ce <= 1'b1;
        rd(VT_CFG_ADDR, d);
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'hFF);
        rd(CT_CFG_ADDR, 8'h3E);
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'h38);
        end_of_charge_raw <= 1'b1;
        wait_hi(0, 100);
        check(n >= 5 && n <= 12, 1);
        end_of_charge_raw <= 1'b0;
        repeat (10) @(posedge clock);
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'h18);
        check(charge_complete, 0);
        end_of_charge_raw <= 1'b1;
        wait_hi(0, 100);
        check(n >= 31 && n <= 40, 1);
        end_of_charge_raw <= 1'b0;
        battery_above_weak_raw <= 1'b1;
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'h10);
        trickle_active <= 1'b1;
        fast_active <= 1'b1;
        wait_hi(1, 31000);
        check(n >= 29995 && n <= 30005, 1);
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'h00);
        trickle_active <= 1'b0;
        fast_active <= 1'b0;
        repeat (3) @(posedge clock);
        check(trickle_timeout, 0);
        check(fast_timeout, 0);
        check(watchdog_timeout, 0);
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'h04);
        repeat (20000) @(posedge clock);
        ctt_host_model_inst.restart(8'h04);
        check(watchdog_timeout, 0);
        wait_hi(2, 33000);
        check(n >= 31990 && n <= 32010, 1);
        check(safety_timeout, 0);
        ctt_host_model_inst.wr(CT_CFG_ADDR, 8'h00);
        repeat (3) @(posedge clock);
        check(watchdog_timeout, 0);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(VT_CFG_ADDR, 8'h6B);
        rd(CT_CFG_ADDR, 8'h38);
        report_and_stop();
    end
endmodule
